// ===== fiber_path_defines.svh
// Functional notes
// - Each channel picks fiber mode from its own signal-detect/enable pin.
// - Fiber path stays inactive whenever the channel runs at 10 Mbps.
// - Fiber mode bypasses speed/duplex negotiation, scrambler and descrambler.
// - Fiber transmitter sends the encoder's 5-bit code stream as NRZI.
// - Two-bit gain select: 11=1.30, 10=1.15, 01=1.00 default, 00=0.85.
// - Sliced receive bits reach clock recovery only while signal detect is high.
// - Signal detect asserted puts the channel in link pass, data valid.
// - Signal detect deasserted puts the channel in link fail, data invalid.
// - Grounded enable pin selects twisted pair and disables the fiber path.
// - Far-end fault works only in fiber mode, off after reset, enable bit.
// - Fault idle with no signal detect sends one zero after 84 ones.
// - Three consecutive received fault intervals set remote fault and the LED.
`ifndef FIBER_PATH_DEFINES_SVH
`define FIBER_PATH_DEFINES_SVH

// Far-end fault pattern shape
`define FAULT_ONES 7'h54
`define FAULT_RUN_OVER 7'h55
`define FAULT_INTERVALS 2'h3

// Output gain selects and codes in hundredths
`define GAIN_SEL_130 2'h3
`define GAIN_SEL_115 2'h2
`define GAIN_SEL_100 2'h1
`define GAIN_SEL_085 2'h0
`define GAIN_CODE_130 8'h82
`define GAIN_CODE_115 8'h73
`define GAIN_CODE_100 8'h64
`define GAIN_CODE_085 8'h55
`define GAIN_CODE_RESET 8'h64

// Code group layout and idle group
`define SYM_BITS 3'h5
`define IDLE_CODE 5'h1f

`endif

// ===== fiber_path_pkg.sv
package fiber_path_pkg;

  // One code group from the block encoder
  typedef struct packed {
    logic idle;
    logic [4:0] code;
  } tx_sym_t;

  // Which media path the channel runs
  typedef enum logic [1:0] {
    PATH_TP10,
    PATH_TP100,
    PATH_FIBER
  } path_t;

endpackage

// ===== sym_fifo.sv
`timescale 1ns/1ps
module sym_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_ff, nxt_wrPtr;
  logic [AW-1:0] rdPtr_ff, nxt_rdPtr;
  logic [AW:0] count_ff, nxt_count;
  logic inReady_ff, nxt_inReady;
  logic outValid_ff, nxt_outValid;
  logic [WIDTH-1:0] outData_ff, nxt_outData;
  logic push, pop;

  // Head register refills whenever empty or drained
  always_comb begin
    push = inValid && inReady_ff;
    pop = (count_ff != '0) && (!outValid_ff || outReady);
    nxt_wrPtr = push ? AW'(wrPtr_ff + 1'b1) : wrPtr_ff;
    nxt_rdPtr = pop ? AW'(rdPtr_ff + 1'b1) : rdPtr_ff;
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = (AW+1)'(count_ff + 1'b1);
    end else if (pop && !push) begin
      nxt_count = (AW+1)'(count_ff - 1'b1);
    end
    // Registered ready looks at the next count, so all DEPTH slots fill, never overflows
    nxt_inReady = nxt_count < (AW+1)'(DEPTH);
    nxt_outValid = pop || (outValid_ff && !outReady);
    nxt_outData = pop ? mem[rdPtr_ff] : outData_ff;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
      inReady_ff <= 1'b0;
      outValid_ff <= 1'b0;
      outData_ff <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
      inReady_ff <= nxt_inReady;
      outValid_ff <= nxt_outValid;
      outData_ff <= nxt_outData;
    end
  end

  // Storage has no reset; only written entries are ever read
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  assign inReady = inReady_ff;
  assign outValid = outValid_ff;
  assign outData = outData_ff;
endmodule // sym_fifo

// ===== fiber_channel_path.sv
`timescale 1ns/1ps
`include "fiber_path_defines.svh"
module fiber_channel_path
  import fiber_path_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic speed100,
  input wire logic sigDetectFiberSelect,
  input wire logic fiberPinGrounded,
  input wire logic farEndFaultSignal,
  input wire logic [1:0] fiberOutGainSel,
  input wire logic encValid,
  output logic encReady,
  input wire tx_sym_t encSym,
  input wire logic txBitTick,
  input wire logic rxBitTick,
  input wire logic fiberRxBit,
  output logic fiberTxP,
  output logic fiberTxN,
  output logic [7:0] fiberGainCode,
  output path_t pathMode,
  output logic fiberMode,
  output logic tpPathEn,
  output logic bypassAutoneg,
  output logic bypassScrambler,
  output logic linkPass,
  output logic cdrBit,
  output logic cdrValid,
  output logic remoteFault,
  output logic indicatorOut0N
);
  // Mode state
  path_t pathMode_ff, nxt_pathMode;
  logic fiberMode_ff, nxt_fiberMode;
  logic tpPathEn_ff, nxt_tpPathEn;
  logic bypass_ff, nxt_bypass;
  logic [7:0] gain_ff, nxt_gain;
  // Transmit state
  logic [4:0] shift_ff, nxt_shift;
  logic [2:0] bitsLeft_ff, nxt_bitsLeft;
  logic curIdle_ff, nxt_curIdle;
  logic [6:0] txOnes_ff, nxt_txOnes;
  logic txP_ff, nxt_txP;
  logic txN_ff, nxt_txN;
  logic txBit, faultIdleEn, fifoValid, fifoReady;
  tx_sym_t fifoSym;
  // Receive state
  logic rxPrev_ff, nxt_rxPrev;
  logic [6:0] rxRun_ff, nxt_rxRun;
  logic [1:0] intervals_ff, nxt_intervals;
  logic link_ff, nxt_link;
  logic cdrBit_ff, nxt_cdrBit;
  logic cdrValid_ff, nxt_cdrValid;
  logic fault_ff, nxt_fault;
  logic ledN_ff, nxt_ledN;
  logic rxNrz;

  // Elastic store between encoder and serializer
  sym_fifo #(
    .WIDTH($bits(tx_sym_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .inValid(encValid),
    .inReady(encReady),
    .inData(encSym),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .outData(fifoSym)
  );

  // Path selection and gain trim
  always_comb begin
    nxt_fiberMode = speed100 && !fiberPinGrounded;
    nxt_tpPathEn = !nxt_fiberMode;
    if (nxt_fiberMode) begin
      nxt_pathMode = PATH_FIBER;
    end else if (speed100) begin
      nxt_pathMode = PATH_TP100;
    end else begin
      nxt_pathMode = PATH_TP10;
    end
    nxt_bypass = nxt_fiberMode;
    case (fiberOutGainSel)
      `GAIN_SEL_130: nxt_gain = `GAIN_CODE_130;
      `GAIN_SEL_115: nxt_gain = `GAIN_CODE_115;
      `GAIN_SEL_100: nxt_gain = `GAIN_CODE_100;
      default: nxt_gain = `GAIN_CODE_085;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pathMode_ff <= PATH_TP10;
      fiberMode_ff <= 1'b0;
      tpPathEn_ff <= 1'b1;
      bypass_ff <= 1'b0;
      gain_ff <= `GAIN_CODE_RESET;
    end else begin
      pathMode_ff <= nxt_pathMode;
      fiberMode_ff <= nxt_fiberMode;
      tpPathEn_ff <= nxt_tpPathEn;
      bypass_ff <= nxt_bypass;
      gain_ff <= nxt_gain;
    end
  end

  // Serializer, fault idle insertion and NRZI line coding
  always_comb begin
    faultIdleEn = farEndFaultSignal && fiberMode_ff && !sigDetectFiberSelect;
    // zero after a full run of ones
    if (curIdle_ff && faultIdleEn) begin
      txBit = txOnes_ff != `FAULT_ONES;
    end else begin
      txBit = shift_ff[4];
    end
    fifoReady = txBitTick && (bitsLeft_ff <= 3'h1);
    nxt_shift = shift_ff;
    nxt_bitsLeft = bitsLeft_ff;
    nxt_curIdle = curIdle_ff;
    nxt_txOnes = txOnes_ff;
    nxt_txP = txP_ff;
    if (txBitTick) begin
      // Saturating run count keeps normal idle harmless
      if (!txBit) begin
        nxt_txOnes = 7'h00;
      end else if (txOnes_ff != `FAULT_RUN_OVER) begin
        nxt_txOnes = 7'(txOnes_ff + 1'b1);
      end else if (curIdle_ff && faultIdleEn) begin
        // A saturated run never reaches the gap; start a fresh one
        nxt_txOnes = 7'h00;
      end
      if (fiberMode_ff && txBit) begin
        nxt_txP = !txP_ff;
      end
      if (bitsLeft_ff <= 3'h1) begin
        // Underrun sends idle rather than stalling the line
        nxt_shift = fifoValid ? fifoSym.code : `IDLE_CODE;
        nxt_curIdle = fifoValid ? fifoSym.idle : 1'b1;
        nxt_bitsLeft = `SYM_BITS;
      end else begin
        nxt_shift = {shift_ff[3:0], 1'b1};
        nxt_bitsLeft = 3'(bitsLeft_ff - 1'b1);
      end
    end
    nxt_txN = !nxt_txP;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= `IDLE_CODE;
      bitsLeft_ff <= 3'h0;
      curIdle_ff <= 1'b1;
      txOnes_ff <= 7'h00;
      txP_ff <= 1'b0;
      txN_ff <= 1'b1;
    end else begin
      shift_ff <= nxt_shift;
      bitsLeft_ff <= nxt_bitsLeft;
      curIdle_ff <= nxt_curIdle;
      txOnes_ff <= nxt_txOnes;
      txP_ff <= nxt_txP;
      txN_ff <= nxt_txN;
    end
  end

  // Receive gating, link state and fault pattern detection
  always_comb begin
    rxNrz = fiberRxBit ^ rxPrev_ff;
    nxt_link = fiberMode_ff && sigDetectFiberSelect;
    nxt_cdrValid = nxt_link;
    nxt_cdrBit = fiberRxBit && nxt_link;
    nxt_rxPrev = rxBitTick ? fiberRxBit : rxPrev_ff;
    nxt_rxRun = rxRun_ff;
    nxt_intervals = intervals_ff;
    if (!nxt_link || !farEndFaultSignal) begin
      nxt_rxRun = 7'h00;
      nxt_intervals = 2'h0;
    end else if (rxBitTick) begin
      if (!rxNrz) begin
        nxt_rxRun = 7'h00;
        if (rxRun_ff == `FAULT_ONES) begin
          if (intervals_ff != `FAULT_INTERVALS) begin
            nxt_intervals = 2'(intervals_ff + 1'b1);
          end
        end else begin
          nxt_intervals = 2'h0;
        end
      end else if (rxRun_ff == `FAULT_ONES) begin
        // Run too long for the pattern
        nxt_rxRun = `FAULT_RUN_OVER;
        nxt_intervals = 2'h0;
      end else if (rxRun_ff != `FAULT_RUN_OVER) begin
        nxt_rxRun = 7'(rxRun_ff + 1'b1);
      end
    end
    nxt_fault = nxt_intervals == `FAULT_INTERVALS;
    nxt_ledN = !nxt_fault;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxPrev_ff <= 1'b0;
      rxRun_ff <= 7'h00;
      intervals_ff <= 2'h0;
      link_ff <= 1'b0;
      cdrBit_ff <= 1'b0;
      cdrValid_ff <= 1'b0;
      fault_ff <= 1'b0;
      ledN_ff <= 1'b1;
    end else begin
      rxPrev_ff <= nxt_rxPrev;
      rxRun_ff <= nxt_rxRun;
      intervals_ff <= nxt_intervals;
      link_ff <= nxt_link;
      cdrBit_ff <= nxt_cdrBit;
      cdrValid_ff <= nxt_cdrValid;
      fault_ff <= nxt_fault;
      ledN_ff <= nxt_ledN;
    end
  end

  // Port drive, each straight from a flop
  assign fiberTxP = txP_ff;
  assign fiberTxN = txN_ff;
  assign fiberGainCode = gain_ff;
  assign pathMode = pathMode_ff;
  assign fiberMode = fiberMode_ff;
  assign tpPathEn = tpPathEn_ff;
  assign bypassAutoneg = bypass_ff;
  assign bypassScrambler = bypass_ff;
  assign linkPass = link_ff;
  assign cdrBit = cdrBit_ff;
  assign cdrValid = cdrValid_ff;
  assign remoteFault = fault_ff;
  assign indicatorOut0N = ledN_ff;

  // Checks on the outputs this block drives
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence faultZeroSent;
    txBitTick && curIdle_ff && faultIdleEn && !txBit;
  endsequence

  sequence faultRunDone;
    rxBitTick && !rxNrz && rxRun_ff == `FAULT_ONES && link_ff;
  endsequence

  fiber_select_a: assert property (
    ##1 fiberMode_ff == $past(speed100 && !fiberPinGrounded))
    else $error("fiber mode does not follow pin and speed");
  slow_speed_off_a: assert property (
    !speed100 |=> !fiberMode_ff && pathMode_ff == PATH_TP10)
    else $error("fiber path active at 10 Mbps");
  bypass_follow_a: assert property (
    ##1 bypassAutoneg == $past(speed100 && !fiberPinGrounded)
      && bypassScrambler == $past(speed100 && !fiberPinGrounded))
    else $error("bypass does not match fiber mode");
  nrzi_code_a: assert property (
    txBitTick && fiberMode_ff |=> (txP_ff != $past(txP_ff)) == $past(txBit)
      && txN_ff == !txP_ff)
    else $error("fiber output not NRZI coded");
  gain_table_a: assert property (
    fiberOutGainSel == `GAIN_SEL_115 ##1 fiberOutGainSel == `GAIN_SEL_115
      |-> gain_ff == `GAIN_CODE_115)
    else $error("gain code wrong for select");
  rx_gate_a: assert property (
    !sigDetectFiberSelect |=> !cdrValid_ff && !cdrBit_ff)
    else $error("receive data passed without signal detect");
  link_pass_a: assert property (
    fiberMode_ff && sigDetectFiberSelect |=> link_ff && cdrValid_ff)
    else $error("link pass missing with signal detect");
  link_fail_a: assert property (
    !sigDetectFiberSelect |=> !link_ff)
    else $error("link pass held without signal detect");
  tp_fallback_a: assert property (
    fiberPinGrounded |=> tpPathEn_ff && !fiberMode_ff)
    else $error("grounded pin did not select twisted pair");
  fault_gated_a: assert property (
    !farEndFaultSignal || !fiberMode_ff |=> !fault_ff)
    else $error("remote fault outside enabled fiber mode");
  fault_gap_a: assert property (
    faultZeroSent |-> (txOnes_ff == `FAULT_ONES)
      ##1 (txP_ff == $past(txP_ff)))
    else $error("fault zero not after 84 ones");
  fault_led_a: assert property (
    faultRunDone ##0 (intervals_ff == 2'h2) && farEndFaultSignal
      && sigDetectFiberSelect && fiberMode_ff |=> fault_ff && !ledN_ff)
    else $error("remote fault not raised on third interval");
  run_break_a: assert property (
    rxBitTick && link_ff && !rxNrz && rxRun_ff != `FAULT_ONES
      |=> intervals_ff == 2'h0)
    else $error("broken run did not restart count");
endmodule // fiber_channel_path

// ===== fiber_xcvr_model.sv
`timescale 1ns/1ps
module fiber_xcvr_model (
  input wire logic mclk,
  input wire logic txP,
  output logic txBitTick,
  output logic rxBitTick,
  output logic fiberRxBit
);
  logic lastP;

  // Ticks idle low, line starts low
  initial begin
    txBitTick = 0;
    rxBitTick = 0;
    fiberRxBit = 0;
    lastP = 0;
  end

  // Align the decoder to the current line level
  task automatic tx_sync();
    @(negedge mclk) lastP = txP;
  endtask

  // Slow pacing leaves room for the output register
  task automatic tx_bit(output logic b);
    @(negedge mclk) txBitTick = 1;
    @(negedge mclk) txBitTick = 0;
    repeat (2) @(negedge mclk);
    b = txP ^ lastP;
    lastP = txP;
  endtask

  // Optical side sends NRZI: a one toggles the line
  task automatic rx_bit(input logic b);
    @(negedge mclk) begin
      rxBitTick = 1;
      fiberRxBit = fiberRxBit ^ b;
    end
    @(negedge mclk) rxBitTick = 0;
  endtask
endmodule // fiber_xcvr_model

// ===== testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  import fiber_path_pkg::*;
  localparam int DEPTH = 4;
  logic mclk = 0, rst_n = 0, speed100 = 0, sigDet = 0, grounded = 0;
  logic faultEn = 0;
  logic [1:0] gainSel = 2'h1;
  logic encValid = 0;
  tx_sym_t encSym = '0;
  logic encReady, txP, txN, txTick, rxTick, rxBit, remoteFault, ledN;
  logic fiberMode, tpPathEn, bypassAn, bypassScr, linkPass, cdrBit, cdrValid;
  logic [7:0] gainCode;
  path_t pathMode;
  int err_total = 0, total_checks = 0, n;
  logic b, fm;
  logic q[$];

  always #2.5 mclk = ~mclk;

  fiber_channel_path #(.FIFO_DEPTH(DEPTH)) uut (.mclk(mclk), .rst_n(rst_n),
    .speed100(speed100), .sigDetectFiberSelect(sigDet),
    .fiberPinGrounded(grounded), .farEndFaultSignal(faultEn),
    .fiberOutGainSel(gainSel), .encValid(encValid), .encReady(encReady),
    .encSym(encSym), .txBitTick(txTick), .rxBitTick(rxTick),
    .fiberRxBit(rxBit), .fiberTxP(txP), .fiberTxN(txN),
    .fiberGainCode(gainCode), .pathMode(pathMode), .fiberMode(fiberMode),
    .tpPathEn(tpPathEn), .bypassAutoneg(bypassAn),
    .bypassScrambler(bypassScr), .linkPass(linkPass), .cdrBit(cdrBit),
    .cdrValid(cdrValid), .remoteFault(remoteFault), .indicatorOut0N(ledN));

  fiber_xcvr_model far (.mclk(mclk), .txP(txP), .txBitTick(txTick),
    .rxBitTick(rxTick), .fiberRxBit(rxBit));

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic set_mode(input logic s, input logic g);
    @(negedge mclk) begin
      speed100 = s;
      grounded = g;
    end
    repeat (2) @(negedge mclk);
  endtask

  // Line must stay all ones for k bits
  task automatic ones_run(input int k);
    repeat (k) begin
      far.tx_bit(b);
      `CHK(b, 1'b1) // plain idle
    end
  endtask

  // One fault interval: a run of ones ended by a zero
  task automatic send_run(input int ones);
    repeat (ones) far.rx_bit(1'b1);
    far.rx_bit(1'b0);
  endtask

  // Watchdog well past the expected run length
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h0fe3));
    repeat (4) @(negedge mclk);
    `CHK({gainCode, fiberMode, ledN, encReady}, {8'h64, 3'b010}) // reset
    repeat (4) @(negedge mclk);
    rst_n = 1;
    // Every pin and speed combination
    for (int i = 0; i < 4; i++) begin
      set_mode(i[1], i[0]);
      fm = i[1] & ~i[0];
      `CHK(fiberMode, fm) // mode pick
      `CHK(tpPathEn, ~fm) // grounded pin
      `CHK({bypassAn, bypassScr}, {fm, fm}) // bypass
      `CHK(pathMode, !i[1] ? PATH_TP10 : fm ? PATH_FIBER : PATH_TP100)
    end
    // Gain steps of 0.15 from 0.85
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk) gainSel = 2'(i);
      repeat (2) @(negedge mclk);
      `CHK(gainCode, 8'(85 + 15 * i)) // gain table
    end
    set_mode(1, 0);
    // Link follows signal detect, data gated
    for (int i = 0; i < 8; i++) begin
      @(negedge mclk) sigDet = i[0];
      far.rx_bit(1'($urandom));
      @(negedge mclk);
      `CHK({linkPass, cdrValid}, {sigDet, sigDet}) // link
      `CHK(cdrBit, sigDet & rxBit) // data gate
    end
    set_mode(0, 0);
    `CHK(linkPass, 1'b0) // slow speed
    set_mode(1, 0);
    // Fill with the line stalled until refused
    n = 0;
    for (int k = 0; k < 12; k++) begin
      @(negedge mclk);
      // Idle flag is harmless while fault signalling is off
      encSym.idle = (k == 0) ? 1'b0 : 1'($urandom);
      encSym.code = 5'($urandom);
      if (k == 0) encSym.code[4] = 0;
      encValid = 1;
      if (encReady) begin
        n++;
        for (int j = 4; j >= 0; j--) q.push_back(encSym.code[j]);
      end
    end
    @(negedge mclk) encValid = 0;
    `CHK(n, DEPTH + 1) // queue size
    // Drain: skip idle ones, then the symbols MSB first
    far.tx_sync();
    b = 1;
    for (int k = 0; k < 20 && b; k++) far.tx_bit(b);
    `CHK(b, q.pop_front()) // first bit
    while (q.size() > 0) begin
      far.tx_bit(b);
      `CHK(b, q.pop_front()) // NRZI data
    end
    `CHK(txN, ~txP) // pair
    ones_run(10);
    @(negedge mclk) sigDet = 0;
    ones_run(100);
    // Fault idle: one zero after each 84 ones
    @(negedge mclk) faultEn = 1;
    n = -1;
    for (int k = 0; k < 260; k++) begin
      far.tx_bit(b);
      if (n >= 0) `CHK(b, 1'(n != 84)) // fault idle
      n = !b ? 0 : (n >= 0 ? n + 1 : -1);
    end
    `CHK(1'(n >= 0), 1'b1) // zero seen
    @(negedge mclk) sigDet = 1;
    ones_run(100);
    // Receive three intervals, then a broken run
    far.rx_bit(1'b0);
    repeat (2) send_run(84);
    repeat (2) @(negedge mclk);
    `CHK({remoteFault, ledN}, 2'b01) // two only
    send_run(84);
    repeat (2) @(negedge mclk);
    `CHK({remoteFault, ledN}, 2'b10) // fault set
    send_run(83);
    repeat (2) @(negedge mclk);
    `CHK(remoteFault, 1'b0) // broken run
    repeat (3) send_run(85);
    repeat (2) @(negedge mclk);
    `CHK(remoteFault, 1'b0) // long run
    repeat (3) send_run(84);
    repeat (2) @(negedge mclk);
    `CHK(remoteFault, 1'b1) // count restart
    @(negedge mclk) faultEn = 0;
    repeat (2) @(negedge mclk);
    `CHK({remoteFault, ledN}, 2'b01) // disabled
    end_of_test();
  end
endmodule // testbench
